// ### hdl/crc_dbg_pkg.sv
// Constants, carrier types and states for the program memory checksum engine.
package crc_dbg_pkg;
  // Link addresses of the four checksum result bytes.
  localparam logic [7:0]  ADDR_BYTE_ZERO  = 8'hA9;
  localparam logic [7:0]  ADDR_BYTE_ONE   = 8'hAA;
  localparam logic [7:0]  ADDR_BYTE_TWO   = 8'hAB;
  localparam logic [7:0]  ADDR_BYTE_THREE = 8'hAC;
  // Reset value of every result byte.
  localparam logic [7:0]  RESULT_RESET    = 8'h00;
  // First address of a whole-memory checksum.
  localparam logic [15:0] MEM_START       = 16'h0000;
  // Low address byte at the start and at the end of a block checksum.
  localparam logic [7:0]  BLOCK_LOW_FIRST = 8'h00;
  localparam logic [7:0]  BLOCK_LOW_LAST  = 8'hFF;
  // Value read back from an unmapped link address.
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // One register write as it crosses from the link domain.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } link_wr_t;

  // Engine states, Gray coded along idle, read, accumulate, done.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_ACC  = 2'b11,
    ST_DONE = 2'b10
  } crc_state_t;
endpackage

// ### hdl/program_memory_crc_debug_pins.sv
// Program memory checksum engine behind the debug link, with shared pin ownership.

//Contract
//- Write byte one starts 32-bit checksum
//- Full checksum starts at address zero
//- Full result spread over four bytes
//- Link traffic only while device halted; only writes are gated by halt, reads are served at any time
//- Halt hands shared pins to debug
//- Write byte zero starts block checksum
//- Block result in bytes one, zero
module program_memory_crc_debug_pins #(
  parameter int          AW         = 16,
  parameter int          MEM_BYTES  = 8192,
  parameter logic [31:0] CRC32_POLY = 32'h04C11DB7,
  parameter logic [15:0] CRC16_POLY = 16'h1021,
  parameter logic [31:0] CRC32_INIT = 32'h00000000,
  parameter logic [15:0] CRC16_INIT = 16'h0000
) (
  // Clocks and reset.
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_link_clk,
  // Halt state from the core.
  input  wire logic                   i_halted,
  // Debug link register port, link clock domain.
  input  wire logic                   i_link_wr,
  input  wire logic                   i_link_rd,
  input  wire logic [7:0]             i_link_addr,
  input  wire logic [7:0]             i_link_wdata,
  output logic      [7:0]             o_link_rdata,
  output logic                        o_link_busy,
  // Program memory read port, one cycle latency.
  output logic                        o_mem_rd,
  output logic      [AW-1:0]          o_mem_addr,
  input  wire logic [7:0]             i_mem_rdata,
  // Shared clock pin, which is the user reset input.
  input  wire logic                   i_clk_pin,
  output logic                        o_user_reset_req,
  // Shared data pin and its two possible drivers.
  input  wire logic                   i_data_pin_in,
  output logic                        o_data_pin_out,
  output logic                        o_data_pin_oe,
  input  wire logic                   i_dbg_data_out,
  input  wire logic                   i_dbg_data_oe,
  input  wire logic                   i_user_data_out,
  input  wire logic                   i_user_data_oe,
  output logic                        o_user_data_in
);
  import crc_dbg_pkg::*;

  // Last address of a whole-memory pass.
  localparam logic [AW-1:0] MEM_LAST = AW'(MEM_BYTES - 1);

  // One byte folded into the running checksum, MSB first.
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d,
                                           input logic wide);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = (wide ? r[31] : r[15]) ^ d[i];
      r  = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ (wide ? CRC32_POLY : {16'h0000, CRC16_POLY});
      end
    end
    if (!wide) begin
      r[31:16] = 16'h0000;
    end
    return r;
  endfunction

  // Link clock domain.
  link_wr_t          wr_hold;    // Last write, held stable for the core to take.
  logic              wr_tgl;     // Toggles once per link write.
  logic [2:0]        pub_sync;   // Publish toggle synchroniser and edge stage.
  logic [1:0]        busy_sync;  // Busy level synchroniser.
  logic [3:0][7:0]   shadow;     // Link-side copy of the result bytes.
  logic              pub_tgl;    // Core toggles it when the result bytes change.
  logic [3:0][7:0]   result;     // Result bytes, core domain.
  logic              busy;       // Engine running, core domain.

  // Capture each link write and signal it by a toggle; data stays put until the next write.
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_hold <= '0;
      wr_tgl  <= 1'b0;
    end else if (i_link_wr) begin
      wr_hold <= '{addr: i_link_addr, data: i_link_wdata};
      wr_tgl  <= ~wr_tgl;
    end
  end

  // Bring the publish toggle and the busy level across.
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pub_sync  <= 3'b000;
      busy_sync <= 2'b00;
    end else begin
      pub_sync  <= {pub_sync[1:0], pub_tgl};
      busy_sync <= {busy_sync[0], busy};
    end
  end

  assign o_link_busy = busy_sync[1];

  // Copy the result bytes once the toggle edge shows they are settled.
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shadow <= {4{RESULT_RESET}};
    end else if (pub_sync[2] ^ pub_sync[1]) begin
      shadow <= result;
    end
  end

  // Registered read data; unmapped addresses read as zero.
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_link_rdata <= UNMAPPED_READ;
    end else if (i_link_rd) begin
      case (i_link_addr)
        ADDR_BYTE_ZERO:  o_link_rdata <= shadow[0];
        ADDR_BYTE_ONE:   o_link_rdata <= shadow[1];
        ADDR_BYTE_TWO:   o_link_rdata <= shadow[2];
        ADDR_BYTE_THREE: o_link_rdata <= shadow[3];
        default:         o_link_rdata <= UNMAPPED_READ;
      endcase
    end
  end

  // Core clock domain.
  logic [2:0]      wr_sync;    // Write toggle synchroniser and edge stage.
  logic            wr_evt;     // One core cycle per link write.
  logic            take;       // Write accepted: halted and engine idle.
  crc_state_t      state;      // Engine state.
  logic            wide;       // High for the whole-memory pass.
  logic [AW-1:0]   end_addr;   // Last address of the pass.
  logic [31:0]     crc;        // Running checksum.
  logic [1:0]      pin_sync;   // Clock pin level synchroniser.
  logic [1:0]      din_sync;   // Data pin level synchroniser.

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_sync <= 3'b000;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
    end
  end

  assign wr_evt = wr_sync[2] ^ wr_sync[1];
  // Writes outside halt or during a pass are dropped whole, so a pass is never disturbed.
  assign take   = wr_evt && i_halted && (state == ST_IDLE);
  assign busy   = (state != ST_IDLE);

  // Engine sequence: issue a read, fold the byte, repeat until the last address.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state      <= ST_IDLE;
      wide       <= 1'b0;
      o_mem_addr <= '0;
      end_addr   <= '0;
      crc        <= 32'h00000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (take && wr_hold.addr == ADDR_BYTE_ONE) begin
            wide       <= 1'b1;
            o_mem_addr <= AW'(MEM_START);
            end_addr   <= MEM_LAST;
            crc        <= CRC32_INIT;
            state      <= ST_READ;
          end else if (take && wr_hold.addr == ADDR_BYTE_ZERO) begin
            wide       <= 1'b0;
            o_mem_addr <= AW'({wr_hold.data, BLOCK_LOW_FIRST});
            end_addr   <= AW'({wr_hold.data, BLOCK_LOW_LAST});
            crc        <= {16'h0000, CRC16_INIT};
            state      <= ST_READ;
          end
        end
        ST_READ: state <= ST_ACC;
        ST_ACC: begin
          crc <= crc_step(crc, i_mem_rdata, wide);
          if (o_mem_addr == end_addr) begin
            state <= ST_DONE;
          end else begin
            o_mem_addr <= o_mem_addr + AW'(1);
            state      <= ST_READ;
          end
        end
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign o_mem_rd = (state == ST_READ);

  // Result bytes: plain stores from the link, checksum results at the end of a pass.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      result  <= {4{RESULT_RESET}};
      pub_tgl <= 1'b0;
    end else if (state == ST_DONE) begin
      pub_tgl <= ~pub_tgl;
      if (wide) begin
        result <= crc;
      end else begin
        result[1] <= crc[15:8];
        result[0] <= crc[7:0];
      end
    end else if (take) begin
      pub_tgl <= ~pub_tgl;
      case (wr_hold.addr)
        ADDR_BYTE_ZERO:  result[0] <= wr_hold.data;
        ADDR_BYTE_ONE:   result[1] <= wr_hold.data;
        ADDR_BYTE_TWO:   result[2] <= wr_hold.data;
        ADDR_BYTE_THREE: result[3] <= wr_hold.data;
        default:         result    <= result;
      endcase
    end
  end

  // Pin levels pass two flops before use.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_sync <= 2'b11;
      din_sync <= 2'b00;
    end else begin
      pin_sync <= {pin_sync[0], i_clk_pin};
      din_sync <= {din_sync[0], i_data_pin_in};
    end
  end

  // While halted the clock pin is link clock, so it must not reset the user logic,
  // and the user sees its data input frozen at the last pre-halt level.
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_user_reset_req <= 1'b0;
      o_user_data_in   <= 1'b0;
    end else begin
      o_user_reset_req <= !pin_sync[1] && !i_halted;
      if (!i_halted) begin
        o_user_data_in <= din_sync[1];
      end
    end
  end

  // The data pin belongs to the debug link only during halt.
  assign o_data_pin_out = i_halted ? i_dbg_data_out : i_user_data_out;
  assign o_data_pin_oe  = i_halted ? i_dbg_data_oe  : i_user_data_oe;
  // Checks on the engine sequence and on the shared pins.
  property p_full_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
    take && wr_hold.addr == ADDR_BYTE_ONE |=> state == ST_READ && wide && o_mem_addr == '0;
  endproperty
  a_full_start: assert property (p_full_start) else $error("full pass did not start at zero");
  property p_block_start;
    @(posedge i_core_clk) disable iff (!i_nrst)
    take && wr_hold.addr == ADDR_BYTE_ZERO
      |=> !wide && o_mem_rd && o_mem_addr == AW'({$past(wr_hold.data), BLOCK_LOW_FIRST});
  endproperty
  a_block_start: assert property (p_block_start) else $error("block pass bad start address");
  property p_walk_order;
    @(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_ACC && o_mem_addr != end_addr |=> o_mem_addr == $past(o_mem_addr) + AW'(1);
  endproperty
  a_walk_order: assert property (p_walk_order) else $error("address did not step by one");
  property p_full_result;
    @(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_DONE && wide |=> result[3] == $past(crc[31:24]) && result[0] == $past(crc[7:0]);
  endproperty
  a_full_result: assert property (p_full_result) else $error("full result misplaced");
  property p_block_result;
    @(posedge i_core_clk) disable iff (!i_nrst)
    state == ST_DONE && !wide |=> result[1] == $past(crc[15:8]) && $stable(result[3]);
  endproperty
  a_block_result: assert property (p_block_result) else $error("block result misplaced");
  property p_no_restart;
    @(posedge i_core_clk) disable iff (!i_nrst)
    wr_evt && busy && state != ST_DONE |=> $stable(end_addr) && $stable(wide);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("pass restarted while busy");
  property p_halt_only;
    @(posedge i_core_clk) disable iff (!i_nrst)
    wr_evt && !i_halted && state == ST_IDLE |=> state == ST_IDLE;
  endproperty
  a_halt_only: assert property (p_halt_only) else $error("write taken while not halted");
  property p_user_frozen;
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_halted ##1 i_halted |-> $stable(o_user_data_in) && !o_user_reset_req;
  endproperty
  a_user_frozen: assert property (p_user_frozen) else $error("user side moved during halt");
  c_full_pass:  cover property (@(posedge i_core_clk) disable iff (!i_nrst) state == ST_DONE && wide);
  c_block_pass: cover property (@(posedge i_core_clk) disable iff (!i_nrst) state == ST_DONE && !wide);
  c_busy_drop:  cover property (@(posedge i_core_clk) disable iff (!i_nrst) wr_evt && busy);
endmodule

// ### sim/prog_mem_model.sv
// Program memory and user application model on the far side of the checksum engine.
module prog_mem_model #(
  parameter int AW    = 16,
  parameter int DEPTH = 512
) (
  // Core clock and halt state.
  input  wire logic          i_core_clk,
  input  wire logic          i_halted,
  // Memory read port.
  input  wire logic          i_mem_rd,
  input  wire logic [AW-1:0] i_mem_addr,
  output logic      [7:0]    o_mem_rdata,
  // User application drive of the shared data pin.
  output logic               o_user_data_out,
  output logic               o_user_data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [DEPTH];  // Contents, filled by the bench.
  // The user side only listens on the reset pin, so it has no output for it.
  initial begin
    o_mem_rdata     = 8'h00;
    o_user_data_out = 1'b0;
    o_user_data_oe  = 1'b0;
  end
  // A byte follows its read by one cycle; otherwise the bus churns so no stale byte passes.
  always @(posedge i_core_clk) begin
    if (i_mem_rd) begin
      o_mem_rdata <= mem[int'(i_mem_addr) % DEPTH];
    end else begin
      o_mem_rdata <= ~o_mem_rdata;
    end
  end
  // The user drive moves only while the device runs.
  always @(negedge i_core_clk) begin
    if (!i_halted) begin
      o_user_data_out <= ~o_user_data_out;
      o_user_data_oe  <= o_user_data_out;
    end
  end
endmodule

// ### sim/test_program_memory_crc_debug_pins.sv
// Self-checking bench for the program memory checksum engine and its shared pins.
module test_program_memory_crc_debug_pins;
  timeunit 1ns;
  timeprecision 1ps;
  import crc_dbg_pkg::*;
  localparam int          DEPTH = 512;  // Short memory keeps each pass brief.
  localparam logic [31:0] P32   = 32'h04C11DB7;
  localparam logic [15:0] P16   = 16'h1021;
  logic        core_clk, link_clk, nrst, halted, link_wr, link_rd, link_busy, mem_rd;
  logic        clk_pin, reset_req, pin_in, pin_out, pin_oe, dbg_out, dbg_oe;
  logic        usr_out, usr_oe, usr_in, last_in;
  logic [7:0]  link_addr, link_wdata, link_rdata, mem_rdata, b;
  logic [15:0] mem_addr;
  logic [31:0] v, e, full;
  logic [7:0]  regs [4] = '{ADDR_BYTE_ZERO, ADDR_BYTE_ONE, ADDR_BYTE_TWO, ADDR_BYTE_THREE};
  int          fails, checks, cycles, addrs[$];
  integer      seed;
  program_memory_crc_debug_pins #(.AW(16), .MEM_BYTES(DEPTH), .CRC32_POLY(P32),
    .CRC16_POLY(P16), .CRC32_INIT(32'h0), .CRC16_INIT(16'h0)) dut (
    .i_core_clk(core_clk), .i_nrst(nrst), .i_link_clk(link_clk), .i_halted(halted),
    .i_link_wr(link_wr), .i_link_rd(link_rd), .i_link_addr(link_addr),
    .i_link_wdata(link_wdata), .o_link_rdata(link_rdata), .o_link_busy(link_busy),
    .o_mem_rd(mem_rd), .o_mem_addr(mem_addr), .i_mem_rdata(mem_rdata),
    .i_clk_pin(clk_pin), .o_user_reset_req(reset_req), .i_data_pin_in(pin_in),
    .o_data_pin_out(pin_out), .o_data_pin_oe(pin_oe), .i_dbg_data_out(dbg_out),
    .i_dbg_data_oe(dbg_oe), .i_user_data_out(usr_out), .i_user_data_oe(usr_oe),
    .o_user_data_in(usr_in));
  prog_mem_model #(.AW(16), .DEPTH(DEPTH)) mdl (.i_core_clk(core_clk), .i_halted(halted),
    .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .o_mem_rdata(mem_rdata),
    .o_user_data_out(usr_out), .o_user_data_oe(usr_oe));
  // Core clock at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Link clock at 15 ns, offset so its edges wander against the core clock.
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Every memory read address is logged to check where a pass starts and how far it goes.
  always @(posedge core_clk) begin
    cycles++;
    if (mem_rd === 1'b1) begin
      addrs.push_back(int'(mem_addr));
    end
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // Compare tasks for wide values and single bits.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // Link write, held for one link edge, then the spacing the port needs.
  task automatic lwr(input logic [7:0] a, input logic [7:0] d);
    @(negedge link_clk);
    link_wr    = 1'b1;
    link_addr  = a;
    link_wdata = d;
    @(negedge link_clk);
    link_wr = 1'b0;
    repeat (3) @(negedge link_clk);
  endtask
  task automatic lrd(input logic [7:0] a, output logic [7:0] d);
    @(negedge link_clk);
    link_rd   = 1'b1;
    link_addr = a;
    @(negedge link_clk);
    link_rd = 1'b0;
    d       = link_rdata;
  endtask
  // Reads all four result bytes, most significant first.
  task automatic rd_all(output logic [31:0] r);
    for (int k = 3; k >= 0; k--) begin
      lrd(regs[k], r[8*k +: 8]);
    end
  endtask
  // Busy must rise and then fall within bounds; results settle a few link cycles later.
  task automatic wait_pass;
    int n;
    n = 0;
    while (link_busy !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    chk1("busy rise", 1'b1, link_busy);
    while (link_busy !== 1'b0 && n < 4 * DEPTH) begin
      @(negedge link_clk);
      n++;
    end
    chk1("busy fall", 1'b0, link_busy);
    repeat (8) @(negedge link_clk);
  endtask
  // Reference checksum, MSB first; the 16-bit form runs in the top half of the register.
  function automatic logic [31:0] crc_ref(input int first, input int count, input int wide);
    logic [31:0] c;
    logic [31:0] poly;
    c    = 32'h0;
    poly = (wide == 32) ? P32 : {P16, 16'h0};
    for (int i = first; i < first + count; i++) begin
      c ^= {mdl.mem[i], 24'h0};
      for (int k = 0; k < 8; k++) begin
        c = c[31] ? ((c << 1) ^ poly) : (c << 1);
      end
    end
    return (wide == 32) ? c : {16'h0, c[31:16]};
  endfunction
  task automatic stop_test;
    $display("Checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    seed = 32'hf02e;
    for (int i = 0; i < DEPTH; i++) begin
      mdl.mem[i] = 8'($random(seed));
    end
    {nrst, halted, link_wr, link_rd, pin_in, dbg_out, dbg_oe, last_in} = '0;
    clk_pin    = 1'b1;
    link_addr  = 8'h00;
    link_wdata = 8'h00;
    repeat (12) @(negedge core_clk);
    nrst   = 1'b1;
    halted = 1'b1;
    foreach (regs[k]) begin
      lrd(regs[k], b);
      chk("reset byte", {24'h0, RESULT_RESET}, {24'h0, b});
    end
    lrd(8'h55, b);
    chk("unmapped", {24'h0, UNMAPPED_READ}, {24'h0, b});
    $display("Test reset values done");
    addrs.delete();
    lwr(ADDR_BYTE_ONE, 8'($random(seed)));
    wait_pass();
    chk("first address", 32'h0, 32'(addrs[0]));
    chk("bytes read", 32'(DEPTH), 32'(addrs.size()));
    full = crc_ref(0, DEPTH, 32);
    rd_all(v);
    chk("full result", full, v);
    $display("Test full pass done");
    for (int h = 0; h < DEPTH / 256; h++) begin
      addrs.delete();
      lwr(ADDR_BYTE_ZERO, 8'(h));
      wait_pass();
      chk("block start", 32'(h * 256), 32'(addrs[0]));
      chk("block bytes", 32'd256, 32'(addrs.size()));
      e = crc_ref(h * 256, 256, 16);
      rd_all(v);
      chk("block result", {full[31:16], e[15:0]}, v);
    end
    $display("Test block passes done");
    // A plain store must come back once the toggle has carried it to the link copy.
    v[7:0] = 8'($random(seed));
    lwr(ADDR_BYTE_TWO, v[7:0]);
    repeat (4) @(negedge link_clk);
    lrd(ADDR_BYTE_TWO, b);
    chk("stored byte", {24'h0, v[7:0]}, {24'h0, b});
    $display("Test plain store done");
    @(negedge core_clk);
    halted = 1'b0;
    lwr(ADDR_BYTE_ONE, 8'h5A);
    repeat (20) @(negedge link_clk);
    chk1("busy while running", 1'b0, link_busy);
    lrd(ADDR_BYTE_ONE, b);
    chk("dropped write", {24'h0, e[15:8]}, {24'h0, b});
    @(negedge core_clk);
    halted = 1'b1;
    lwr(ADDR_BYTE_ONE, 8'hC3);
    lwr(ADDR_BYTE_ZERO, 8'h01);
    wait_pass();
    rd_all(v);
    chk("no restart", full, v);
    $display("Test refused writes done");
    // A second reset in mid-run must clear every result byte again.
    @(negedge core_clk);
    nrst = 1'b0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    rd_all(v);
    chk("reset again", 32'h0, v);
    $display("Test second reset done");
    for (int t = 0; t < 12; t++) begin
      @(negedge core_clk);
      {halted, clk_pin, pin_in, dbg_out, dbg_oe} = 5'($random(seed));
      repeat (4) @(negedge core_clk);
      chk1("pin out", halted ? dbg_out : usr_out, pin_out);
      chk1("pin enable", halted ? dbg_oe : usr_oe, pin_oe);
      chk1("reset request", !clk_pin && !halted, reset_req);
      last_in = halted ? last_in : pin_in;
      chk1("user data in", last_in, usr_in);
    end
    $display("Test pin sharing done");
    stop_test();
  end
endmodule
